//--- logic/synth_cfg_defs.vh
// Constants for the synthesizer serial reconfiguration block.
// Function
// - Configuration lives in a 27-bit shift register fed serially on configuration clock.
// - Loader presents bit by rising edge; device captures on following falling edge.
// - Bit leaving the far end of the shift register drives serial output.
// - First bit shifted lands in bit 26; word goes most significant first.
// - Serial configuration applies only when test mode is enabled; else static.
// - Reference divider is bits 3:0, feedback divider bits 10:4.
// - Output divider is bits 13:11, filter range bits 16:14.
// - Lock goes high only with frequency lock and good phase lock.
// - Bypass powers the core down and passes the reference through.
// - Low-power hold latches output level so it stops toggling.
// - Feedback fine delay has 16 steps of 0.15 ns, fixed or dynamic.
// - Fixed setting n gives n+1 unit delay steps.
// - Extra output delay applies only to single port or port A.
// - Single-port phase shifter offers 0 or 90 degree outputs.
// - Two-port shifter: divide-by-4 gives B 0/90 degrees; divide-by-7 gives 3.5:1 or 7:1.
`ifndef SYNTH_CFG_DEFS_VH
`define SYNTH_CFG_DEFS_VH
`define CFG_W 27
`define CFG_MSB 26
`define REFDIV_LSB 0
`define REFDIV_W 4
`define FBDIV_LSB 4
`define FBDIV_W 7
`define OUTDIV_LSB 11
`define OUTDIV_W 3
`define FILT_LSB 14
`define FILT_W 3
`define STEP_PS 150
`define DLY_W 4
`define DLY_MAX_STEPS 16
`define LOCK_CYCLES 64
`define CNT_W 8
`endif

//--- logic/synth_cfg_shift.v
// Configuration shift register stored in the core clock domain.
`timescale 1ns/1ps
module synth_cfg_shift #(
  parameter WIDTH = 27
) (
  input wire i_core_clk,
  input wire i_rst_b,
  input wire i_shift,
  input wire i_bit,
  output reg [WIDTH-1:0] o_word
);
  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_word <= {WIDTH{1'b0}};
    end else if (i_shift) begin
      // Left shift so the first bit ends at the top after a full load.
      o_word <= {o_word[WIDTH-2:0], i_bit};
    end
  end
endmodule // synth_cfg_shift

//--- logic/synth_reconfig.v
// Synthesizer control with serial runtime reconfiguration.
`timescale 1ns/1ps
`include "synth_cfg_defs.vh"
module synth_reconfig #(
  parameter TEST_MODE = 1,
  parameter LOCK_CYCLES = `LOCK_CYCLES,
  parameter [`REFDIV_W-1:0] STATIC_REFDIV = 4'h0,
  parameter [`FBDIV_W-1:0] STATIC_FBDIV = 7'h00,
  parameter [`OUTDIV_W-1:0] STATIC_OUTDIV = 3'h1,
  parameter [`FILT_W-1:0] STATIC_FILT = 3'h1,
  parameter FB_DELAY_DYNAMIC = 0,
  parameter OUT_DELAY_DYNAMIC = 0,
  parameter [`DLY_W-1:0] FB_DELAY_FIXED = 4'h0,
  parameter [`DLY_W-1:0] OUT_DELAY_FIXED = 4'h0,
  parameter TWO_PORT = 0,
  parameter DIV7_MODE = 0
) (
  input wire i_core_clk,
  input wire i_rst_b,
  input wire i_cfg_clk,
  input wire i_cfg_serial_in,
  input wire i_synth_reset_n,
  input wire i_bypass,
  input wire i_low_power_hold,
  input wire i_ref_clk,
  input wire i_freq_locked,
  input wire i_phase_good,
  input wire i_phase_90,
  input wire i_half_ratio,
  input wire [7:0] i_delay_select_inputs,
  input wire i_synth_clk,
  output reg o_cfg_serial_out,
  output reg o_lock,
  output reg o_core_power_down,
  output reg o_synth_out_fabric,
  output reg o_synth_out_global_net,
  output reg o_port_b_out,
  output reg [`REFDIV_W-1:0] o_reference_divider,
  output reg [`FBDIV_W-1:0] o_feedback_divider,
  output reg [`OUTDIV_W-1:0] o_output_divider,
  output reg [`FILT_W-1:0] o_filter_range,
  output reg [`DLY_W:0] o_fb_delay_steps,
  output reg [`DLY_W:0] o_out_delay_steps,
  output reg [11:0] o_fb_delay_ps,
  output reg o_port_b_phase_90,
  output reg [1:0] o_port_b_ratio
);
  localparam ST_RESET = 2'h0;
  localparam ST_ACQUIRE = 2'h1;
  localparam ST_LOCKED = 2'h2;

  // Two-flop synchronisers for everything arriving from outside.
  reg [2:0] sclk_s_r;
  reg [1:0] sdi_s_r;
  reg [1:0] rstn_s_r;
  reg [1:0] byp_s_r;
  reg [1:0] hold_s_r;
  reg [1:0] fl_s_r;
  reg [1:0] pg_s_r;
  reg [1:0] ref_s_r;
  reg [1:0] gen_s_r;
  reg [1:0] ph90_s_r;
  reg [1:0] half_s_r;
  // The select word is treated as quasi-static: a change that lands across
  // a sampling edge may show one mixed value for a single cycle.
  reg [7:0] dsel_a_r;
  reg [7:0] dsel_b_r;
  wire [`CFG_W-1:0] cfg_word;
  wire sclk_fall;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [`CNT_W-1:0] lock_cnt_r;
  reg out_level;

  function [`DLY_W:0] delay_steps;
    input [`DLY_W-1:0] n;
    begin
      delay_steps = {1'b0, n} + 5'h01;
    end
  endfunction

  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      sclk_s_r <= 3'h0;
      sdi_s_r <= 2'h0;
      rstn_s_r <= 2'h0;
      byp_s_r <= 2'h0;
      hold_s_r <= 2'h0;
      fl_s_r <= 2'h0;
      pg_s_r <= 2'h0;
      ref_s_r <= 2'h0;
      gen_s_r <= 2'h0;
      ph90_s_r <= 2'h0;
      half_s_r <= 2'h0;
      dsel_a_r <= 8'h00;
      dsel_b_r <= 8'h00;
    end else begin
      sclk_s_r <= {sclk_s_r[1:0], i_cfg_clk};
      sdi_s_r <= {sdi_s_r[0], i_cfg_serial_in};
      rstn_s_r <= {rstn_s_r[0], i_synth_reset_n};
      byp_s_r <= {byp_s_r[0], i_bypass};
      hold_s_r <= {hold_s_r[0], i_low_power_hold};
      fl_s_r <= {fl_s_r[0], i_freq_locked};
      pg_s_r <= {pg_s_r[0], i_phase_good};
      ref_s_r <= {ref_s_r[0], i_ref_clk};
      gen_s_r <= {gen_s_r[0], i_synth_clk};
      ph90_s_r <= {ph90_s_r[0], i_phase_90};
      half_s_r <= {half_s_r[0], i_half_ratio};
      dsel_a_r <= i_delay_select_inputs;
      dsel_b_r <= dsel_a_r;
    end
  end

  // The data bit is one sync stage ahead of the clock edge seen here, so
  // it was stable at the rising edge and is taken at the falling edge.
  assign sclk_fall = sclk_s_r[2] & ~sclk_s_r[1];

  synth_cfg_shift #(
    .WIDTH(`CFG_W)
  ) u_shift (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_shift(sclk_fall),
    .i_bit(sdi_s_r[1]),
    .o_word(cfg_word)
  );

  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_cfg_serial_out <= 1'b0;
    end else begin
      o_cfg_serial_out <= cfg_word[`CFG_MSB];
    end
  end

  // Settings are taken only while the synthesizer reset is released, so a
  // half-shifted word never reaches the dividers.
  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_reference_divider <= STATIC_REFDIV;
      o_feedback_divider <= STATIC_FBDIV;
      o_output_divider <= STATIC_OUTDIV;
      o_filter_range <= STATIC_FILT;
    end else if (TEST_MODE != 0 && rstn_s_r[1]) begin
      o_reference_divider <=
        cfg_word[`REFDIV_LSB +: `REFDIV_W];
      o_feedback_divider <= cfg_word[`FBDIV_LSB +: `FBDIV_W];
      o_output_divider <= cfg_word[`OUTDIV_LSB +: `OUTDIV_W];
      o_filter_range <= cfg_word[`FILT_LSB +: `FILT_W];
    end else if (TEST_MODE == 0) begin
      o_reference_divider <= STATIC_REFDIV;
      o_feedback_divider <= STATIC_FBDIV;
      o_output_divider <= STATIC_OUTDIV;
      o_filter_range <= STATIC_FILT;
    end
  end

  // Delay stages: fixed parameter or the dynamic select inputs.
  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_fb_delay_steps <= 5'h00;
      o_out_delay_steps <= 5'h00;
      o_fb_delay_ps <= 12'h000;
    end else begin
      o_fb_delay_steps <= delay_steps(FB_DELAY_DYNAMIC != 0 ?
        dsel_b_r[3:0] : FB_DELAY_FIXED);
      // Only one extra stage exists: it serves port A or the single port.
      o_out_delay_steps <= delay_steps(OUT_DELAY_DYNAMIC != 0 ?
        dsel_b_r[7:4] : OUT_DELAY_FIXED);
      // Sixteen steps reach 2400 ps, so the product needs twelve bits.
      o_fb_delay_ps <= o_fb_delay_steps * 12'd`STEP_PS;
    end
  end

  // Shifter modes.
  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_port_b_phase_90 <= 1'b0;
      o_port_b_ratio <= 2'h0;
    end else if (TWO_PORT == 0 || DIV7_MODE == 0) begin
      o_port_b_phase_90 <= ph90_s_r[1];
      o_port_b_ratio <= 2'h0;
    end else begin
      o_port_b_phase_90 <= 1'b0;
      o_port_b_ratio <= half_s_r[1] ? 2'h1 : 2'h2;
    end
  end

  // Lock tracking.
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RESET: begin
        if (rstn_s_r[1] && !byp_s_r[1]) begin
          state_nxt = ST_ACQUIRE;
        end
      end
      ST_ACQUIRE: begin
        if (lock_cnt_r >= LOCK_CYCLES[`CNT_W-1:0]) begin
          state_nxt = ST_LOCKED;
        end
      end
      ST_LOCKED: begin
        if (!(fl_s_r[1] && pg_s_r[1])) begin
          state_nxt = ST_ACQUIRE;
        end
      end
      default: begin
        state_nxt = ST_RESET;
      end
    endcase
    if (!rstn_s_r[1] || byp_s_r[1]) begin
      state_nxt = ST_RESET;
    end
  end

  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      state_r <= ST_RESET;
      lock_cnt_r <= {`CNT_W{1'b0}};
      o_lock <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_ACQUIRE && fl_s_r[1] && pg_s_r[1]) begin
        lock_cnt_r <= lock_cnt_r + 8'h01;
      end else begin
        lock_cnt_r <= {`CNT_W{1'b0}};
      end
      o_lock <= (state_nxt == ST_LOCKED);
    end
  end

  // Output path: bypass passes the reference, hold freezes the level.
  always @* begin
    if (byp_s_r[1]) begin
      out_level = ref_s_r[1];
    end else begin
      out_level = gen_s_r[1];
    end
  end

  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_core_power_down <= 1'b1;
      o_synth_out_fabric <= 1'b0;
      o_synth_out_global_net <= 1'b0;
      o_port_b_out <= 1'b0;
    end else begin
      o_core_power_down <= byp_s_r[1];
      if (!hold_s_r[1]) begin
        o_synth_out_fabric <= out_level;
        o_synth_out_global_net <= out_level;
        o_port_b_out <= out_level;
      end
    end
  end
endmodule // synth_reconfig

//--- bench/synth_reconfig_sva.sv
// Concurrent checks for the serial reconfiguration block.
`timescale 1ns/1ps
module synth_reconfig_sva #(
  parameter LOCK_CYCLES = 64
) (
  input wire i_core_clk,
  input wire i_rst_b,
  input wire i_cfg_clk,
  input wire i_synth_reset_n,
  input wire i_bypass,
  input wire i_low_power_hold,
  input wire i_freq_locked,
  input wire i_phase_good,
  input wire o_cfg_serial_out,
  input wire o_lock,
  input wire o_core_power_down,
  input wire o_synth_out_fabric,
  input wire [3:0] o_reference_divider,
  input wire [4:0] o_fb_delay_steps,
  input wire [11:0] o_fb_delay_ps
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  // Margins cover the input synchronisers of the level controls.
  sequence synth_held;
    (!i_synth_reset_n)[*5];
  endsequence
  sequence lock_good;
    (i_freq_locked && i_phase_good && i_synth_reset_n && !i_bypass)[*8];
  endsequence
  chk_lock_in_reset: assert property (synth_held |-> !o_lock)
    else $error("lock high in synth reset");
  chk_div_frozen: assert property (synth_held |-> $stable(o_reference_divider))
    else $error("divider moved in synth reset");
  chk_lock_needs_both: assert property ($rose(o_lock) |->
    $past(i_freq_locked && i_phase_good, LOCK_CYCLES))
    else $error("lock rose without lock inputs");
  chk_lock_arrives: assert property (lock_good |-> ##[0:8] o_lock)
    else $error("lock late");
  chk_bypass_down: assert property (i_bypass[*4] |-> o_core_power_down && !o_lock)
    else $error("bypass not honoured");
  chk_hold_freezes: assert property (i_low_power_hold[*5] |-> $stable(o_synth_out_fabric))
    else $error("output toggles in hold");
  chk_sout_quiet: assert property ((!i_cfg_clk)[*6] |-> $stable(o_cfg_serial_out))
    else $error("serial out moved without falling edge");
  chk_delay_ps: assert property (o_fb_delay_ps ==
    {7'h00, $past(o_fb_delay_steps)} * 12'h096)
    else $error("delay ps mismatch");
endmodule // synth_reconfig_sva
bind synth_reconfig synth_reconfig_sva #(.LOCK_CYCLES(LOCK_CYCLES)) u_sva (.*);

//--- bench/synth_cfg_loader.sv
// Behavioural loader that shifts a configuration word into the block.
`timescale 1ns/1ps
module synth_cfg_loader (
  output reg o_cfg_clk,
  output reg o_cfg_serial_in,
  output reg o_synth_reset_n
);
  initial begin
    o_cfg_clk = 1'b0;
    o_cfg_serial_in = 1'b0;
    o_synth_reset_n = 1'b0;
  end
  task load(input [26:0] w);
    integer i;
    begin
      o_synth_reset_n = 1'b0;
      #96;
      for (i = 26; i >= 0; i = i - 1) begin
        o_cfg_serial_in = w[i];
        #8 o_cfg_clk = 1'b1;
        #32 o_cfg_clk = 1'b0;
        #24;
      end
      // Idle data is inverted so a stale bit is never mistaken for data.
      o_cfg_serial_in = ~w[0];
      #16 o_synth_reset_n = 1'b1;
    end
  endtask
endmodule // synth_cfg_loader

//--- bench/synth_reconfig_tb.sv
// Self-checking bench for the serial reconfiguration block.
`timescale 1ns/1ps
module synth_reconfig_tb;
  reg i_core_clk = 1'b0, i_rst_b = 1'b0, i_bypass = 1'b0;
  reg i_low_power_hold = 1'b0, i_ref_clk = 1'b0, i_synth_clk = 1'b0;
  reg i_freq_locked = 1'b0, i_phase_good = 1'b0, i_phase_90 = 1'b0;
  reg i_half_ratio = 1'b0, v;
  reg [7:0] i_delay_select_inputs = 8'h00;
  reg [31:0] r;
  reg [26:0] w;
  integer k, i, err_total = 0, n_compared = 0;
  wire i_cfg_clk, i_cfg_serial_in, i_synth_reset_n;
  wire o_cfg_serial_out, o_lock, o_core_power_down, o_synth_out_fabric;
  wire o_synth_out_global_net, o_port_b_out, o_port_b_phase_90;
  wire [1:0] o_port_b_ratio;
  wire [3:0] o_reference_divider;
  wire [6:0] o_feedback_divider;
  wire [2:0] o_output_divider, o_filter_range;
  wire [4:0] o_fb_delay_steps, o_out_delay_steps;
  wire [11:0] o_fb_delay_ps;
  synth_reconfig #(.LOCK_CYCLES(4), .FB_DELAY_FIXED(4'h5),
    .OUT_DELAY_FIXED(4'hf)) dut (.*);
  synth_cfg_loader ld (.o_cfg_clk(i_cfg_clk),
    .o_cfg_serial_in(i_cfg_serial_in), .o_synth_reset_n(i_synth_reset_n));
  always #4 i_core_clk = ~i_core_clk;
  always #25 i_ref_clk = ~i_ref_clk;
  always #3 i_synth_clk = ~i_synth_clk;
  function [16:0] exp_div(input [26:0] x);
    exp_div = {x[16:14], x[13:11], x[10:4], x[3:0]};
  endfunction
  task chk(input [26:0] g, input [26:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        $display("BAD %0t got %h exp %h", $time, g, e);
        err_total = err_total + 1;
      end
    end
  endtask
  task end_sim;
    begin
      if (err_total == 0 && n_compared > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task wait_neg(input integer n);
    repeat (n) @(negedge i_core_clk);
  endtask
  initial begin
    #60000;
    err_total = err_total + 1;
    end_sim;
  end
  initial begin
    r = $urandom(32'hcfc6f0f6);
    wait_neg(20);
    i_rst_b = 1'b1;
    wait_neg(4);
    chk({o_fb_delay_steps, o_out_delay_steps}, {5'h06, 5'h10});
    for (k = 0; k < 4; k = k + 1) begin
      r = $urandom;
      w = (k == 0) ? 27'h20054f1 : (k == 1) ? 27'h7ffffff : r[26:0];
      {i_phase_90, i_half_ratio, i_delay_select_inputs} = r[9:0];
      i_freq_locked = 1'b1;
      i_phase_good = 1'b1;
      ld.load(w);
      wait_neg(6);
      chk(o_cfg_serial_out, w[26]);
      chk({o_filter_range, o_output_divider, o_feedback_divider,
        o_reference_divider}, exp_div(w));
      for (i = 0; i < 40 && o_lock !== 1'b1; i = i + 1)
        wait_neg(1);
      chk(o_lock, 1'b1);
      i_phase_good = 1'b0;
      wait_neg(6);
      chk(o_lock, 1'b0);
      i_phase_good = 1'b1;
      i_bypass = 1'b1;
      wait_neg(6);
      chk({o_core_power_down, o_lock}, 2'b10);
      i_bypass = 1'b0;
      i_low_power_hold = 1'b1;
      wait_neg(5);
      v = o_synth_out_fabric;
      wait_neg(10);
      chk(o_synth_out_fabric, v);
      chk({o_synth_out_global_net, o_port_b_out, o_port_b_phase_90,
        o_port_b_ratio}, {v, v, i_phase_90, 2'b00});
      i_low_power_hold = 1'b0;
    end
    wait_neg(20);
    i_rst_b = 1'b0;
    wait_neg(3);
    chk({o_lock, o_core_power_down}, 2'b01);
    end_sim;
  end
endmodule // synth_reconfig_tb
